/* File: hw/cbi_pkg.sv */
// cbi_pkg: shared constants and types for the processor pin block.
// assumes a single 40 MHz clock; all users write cbi_pkg::name.
package cbi_pkg;
	// ==========================================================
	// timing
	localparam int CLK_NS = 25;
	localparam int PHI2_HALF_NS = 100;
	localparam int HALF_CYC = (PHI2_HALF_NS + CLK_NS - 1) / CLK_NS;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0c;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_PC = 8'h14;
	localparam logic [7:0] OFS_SP = 8'h18;
	localparam logic [7:0] OFS_OPADDR = 8'h1c;
	localparam logic [7:0] OFS_INSTR_END = 8'h20;

	// ==========================================================
	// field positions
	localparam int CB_E = 0;
	localparam int CB_M = 1;
	localparam int CB_X = 2;
	localparam int CB_I = 3;
	localparam int CB_WAIT = 4;
	localparam int CB_STOP = 5;
	localparam int CM_WR = 0;
	localparam int CM_WIDE = 1;
	localparam int CM_RMW = 2;
	localparam int SB_STATE = 8;

	// ==========================================================
	// reset values, vectors and lock lengths
	localparam logic [3:0] RST_FLAGS = 4'hf;
	localparam logic [15:0] RST_SP = 16'h01ff;
	localparam logic [15:0] RST_PC = 16'h0000;
	localparam logic [15:0] VEC_CANCEL_EMU = 16'hfff8;
	localparam logic [15:0] VEC_CANCEL_NAT = 16'hffe8;
	localparam logic [15:0] VEC_NMI_EMU = 16'hfffa;
	localparam logic [15:0] VEC_NMI_NAT = 16'hffea;
	localparam logic [15:0] VEC_IRQ_EMU = 16'hfffe;
	localparam logic [15:0] VEC_IRQ_NAT = 16'hffee;
	localparam logic [2:0] LOCK_SHORT = 3'h3;
	localparam logic [2:0] LOCK_LONG = 3'h5;

	// ==========================================================
	// types
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_RD_LO = 4'h1, ST_RD_HI = 4'h2,
		ST_MODIFY = 4'h3, ST_WR_LO = 4'h4, ST_WR_HI = 4'h5,
		ST_PUSH_HI = 4'h6, ST_PUSH_LO = 4'h7, ST_VEC_LO = 4'h8,
		ST_VEC_HI = 4'h9
	} cbi_state_t;
	typedef enum logic [1:0] {
		K_CANCEL = 2'h0, K_NMI = 2'h1, K_IRQ = 2'h2
	} cbi_kind_t;
	typedef struct packed {
		logic [23:0] addr;
		logic wr;
		logic lock;
		logic [7:0] wdata;
	} cbi_cyc_t;
	typedef struct packed {
		logic i;
		logic x;
		logic m;
		logic e;
	} cbi_flags_t;
endpackage

/* File: hw/cbi_sync.sv */
// cbi_sync: two-flop synchroniser, one chain per bit.
// assumes asynchronous inputs; INIT is the idle level of each bit.
module cbi_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	for (genvar b = 0; b < W; b++) begin : g_bit
		always_ff @(posedge clk) begin
			if (rst) begin
				meta_r[b] <= INIT[b];
				q[b] <= INIT[b];
			end else begin
				meta_r[b] <= d[b];
				q[b] <= meta_r[b];
			end
		end
	end
endmodule // cbi_sync

/* File: hw/cbi_phase.sv */
// cbi_phase: phase-2 and phase-1 clock outputs from a divider.
// assumes HALF >= 3 system clocks per half period.
module cbi_phase #(
	parameter int HALF = cbi_pkg::HALF_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic freeze_req,
	output logic phi1,
	output logic phi2,
	output logic rise_tick,
	output logic fall_tick,
	output logic mid_tick,
	output logic frozen
);
	logic [7:0] cnt_r;
	logic end_w;

	assign end_w = ~frozen && cnt_r == 8'(HALF - 1);
	assign rise_tick = end_w & ~phi2;
	assign fall_tick = end_w & phi2 & ~freeze_req;
	assign mid_tick = ~frozen && cnt_r == 8'(HALF / 2 - 1);

	always_ff @(posedge clk) begin
		if (rst || frozen || end_w)
			cnt_r <= 8'h00;
		else
			cnt_r <= cnt_r + 8'h01;
	end

	// freeze only at the end of a high half: phase 2 stays high
	always_ff @(posedge clk) begin
		if (rst) begin
			phi2 <= 1'b0;
			phi1 <= 1'b1;
			frozen <= 1'b0;
		end else if (frozen) begin
			if (!freeze_req)
				frozen <= 1'b0;
		end else if (end_w) begin
			if (phi2 && freeze_req) begin
				frozen <= 1'b1;
			end else begin
				phi2 <= ~phi2;
				phi1 <= phi2;
			end
		end
	end

	property p_frozen;
		@(posedge clk) disable iff (rst) frozen |-> phi2 && !phi1;
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("halted clocks not parked");
endmodule // cbi_phase

/* File: hw/cbi_top.sv */
// cbi_top: pin-side bus, status and interrupt logic of a 16-bit cpu.
// assumes an apb master on the CLOCK domain; pins are asynchronous.
//
// Chosen here: the register offsets and the APB interface to the registers.

module cbi_top #(
	parameter int HALF = cbi_pkg::HALF_CYC
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// address, bank/data and direction pins
	output logic [15:0] ADDR_LINES,
	output logic ADDR_LINES_OE_N,
	output logic [7:0] MUXED_BANK_DATA_BUS,
	input wire logic [7:0] MUXED_BANK_DATA_BUS_SENSE,
	output logic MUXED_BANK_DATA_BUS_OE_N,
	output logic RW,
	output logic RW_OE_N,
	input wire logic BUS_DRIVE_EN,
	// interrupt pins
	input wire logic CANCEL_N,
	input wire logic IRQ_N,
	input wire logic NMI_N,
	// status and clock pins
	output logic EMU_STATUS,
	output logic WIDTH_FLAGS,
	output logic BUS_LOCK_N,
	output logic PHI1_OUT,
	output logic PHI2_OUT
);
	// ==========================================================
	// declarations
	cbi_pkg::cbi_state_t state_r, state_nxt;
	cbi_pkg::cbi_kind_t kind_r, kind_sel;
	cbi_pkg::cbi_flags_t flags_r;
	cbi_pkg::cbi_cyc_t cur_r, cyc_next, cyc_now;
	logic [15:0] pc_r, sp_r, opaddr_r, ret_r, data_r, vec_w;
	logic [23:0] addr_r, addr_p1;
	logic [7:0] vec_lo_r, mux_s, mux_r, addr_hi_unused;
	logic [2:0] irqs_s;
	logic [2:0] lk_cnt_r;
	logic [31:0] rd_data;
	logic rd_err, wr_en, busy, wake, int_any, inhibit_r, waiting_r;
	logic stop_req_r, boundary_r, cmd_pend_r, cmd_wr_r, cmd_wide_r;
	logic cmd_rmw_r, armed_r, cancel_pend_r, nmi_d_r, nmi_pend_r;
	logic nmi_edge, phi2_w, rise_tick, fall_tick, mid_tick, frozen;
	logic mux_oe_n_r, rw_r, lock_n_r, width_r, emu_r;

	// ==========================================================
	// pin synchronisers and phase generator
	cbi_sync #(.W(11), .INIT(11'h7ff)) u_sync (
		.clk(CLOCK),
		.rst(RST),
		.d({MUXED_BANK_DATA_BUS_SENSE, NMI_N, IRQ_N, CANCEL_N}),
		.q({mux_s, irqs_s})
	);

	cbi_phase #(.HALF(HALF)) u_phase (
		.clk(CLOCK),
		.rst(RST),
		.freeze_req(stop_req_r),
		.phi1(PHI1_OUT),
		.phi2(phi2_w),
		.rise_tick(rise_tick),
		.fall_tick(fall_tick),
		.mid_tick(mid_tick),
		.frozen(frozen)
	);
	assign PHI2_OUT = phi2_w;

	// ==========================================================
	// apb slave: zero wait, answer latched in the setup cycle
	assign wr_en = PSEL & PENABLE & PWRITE & PREADY;
	assign busy = (state_r != cbi_pkg::ST_IDLE) | cmd_pend_r;

	always_comb begin
		rd_data = 32'h0;
		rd_err = 1'b0;
		case (PADDR)
		cbi_pkg::OFS_CTRL: begin
			rd_data[3:0] = flags_r;
			rd_data[cbi_pkg::CB_WAIT] = waiting_r;
			rd_data[cbi_pkg::CB_STOP] = stop_req_r;
		end
		cbi_pkg::OFS_STATUS: begin
			rd_data[7:0] = {1'b0, ~irqs_s[1], nmi_pend_r, cancel_pend_r,
				inhibit_r, frozen, waiting_r, busy};
			rd_data[cbi_pkg::SB_STATE +: 4] = state_r;
		end
		cbi_pkg::OFS_ADDR: rd_data[23:0] = addr_r;
		cbi_pkg::OFS_DATA: rd_data[15:0] = data_r;
		cbi_pkg::OFS_CMD: rd_data[2:0] = {cmd_rmw_r, cmd_wide_r, cmd_wr_r};
		cbi_pkg::OFS_PC: rd_data[15:0] = pc_r;
		cbi_pkg::OFS_SP: rd_data[15:0] = sp_r;
		cbi_pkg::OFS_OPADDR: rd_data[15:0] = opaddr_r;
		cbi_pkg::OFS_INSTR_END: rd_data = 32'h0;
		default: rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
			PREADY <= 1'b0;
		end else begin
			PREADY <= 1'b1;
			if (PSEL && !PENABLE) begin
				PRDATA <= PWRITE ? 32'h0 : rd_data;
				PSLVERR <= rd_err;
			end
		end
	end

	// ==========================================================
	// software-visible processor state
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			flags_r <= cbi_pkg::RST_FLAGS;
			stop_req_r <= 1'b0;
		end else begin
			if (wr_en && PADDR == cbi_pkg::OFS_CTRL) begin
				stop_req_r <= PWDATA[cbi_pkg::CB_STOP];
				if (!inhibit_r)
					flags_r <= PWDATA[3:0];
			end
			if (fall_tick && state_r == cbi_pkg::ST_VEC_HI)
				flags_r.i <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			pc_r <= cbi_pkg::RST_PC;
		else if (fall_tick && state_r == cbi_pkg::ST_VEC_HI)
			pc_r <= {mux_s, vec_lo_r};
		else if (wr_en && !inhibit_r && (PADDR == cbi_pkg::OFS_PC ||
				PADDR == cbi_pkg::OFS_INSTR_END))
			pc_r <= PWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			sp_r <= cbi_pkg::RST_SP;
		else if (fall_tick && state_r == cbi_pkg::ST_VEC_HI)
			sp_r <= sp_r - 16'h2;
		else if (wr_en && !inhibit_r && PADDR == cbi_pkg::OFS_SP)
			sp_r <= PWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			opaddr_r <= 16'h0;
			addr_r <= 24'h0;
		end else if (wr_en && !busy) begin
			if (PADDR == cbi_pkg::OFS_OPADDR)
				opaddr_r <= PWDATA[15:0];
			if (PADDR == cbi_pkg::OFS_ADDR)
				addr_r <= PWDATA[23:0];
		end
	end

	// data register: byte captures, read-modify-write increment
	always_ff @(posedge CLOCK) begin
		if (RST)
			data_r <= 16'h0;
		else if (fall_tick && state_r == cbi_pkg::ST_RD_LO)
			data_r[7:0] <= mux_s;
		else if (fall_tick && state_r == cbi_pkg::ST_RD_HI)
			data_r[15:8] <= mux_s;
		else if (fall_tick && state_r == cbi_pkg::ST_MODIFY)
			data_r <= cmd_wide_r ? data_r + 16'h1
				: {data_r[15:8], data_r[7:0] + 8'h1};
		else if (wr_en && !inhibit_r && !busy &&
				PADDR == cbi_pkg::OFS_DATA)
			data_r <= PWDATA[15:0];
	end

	// command is refused while a sequence is pending or running
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			cmd_pend_r <= 1'b0;
			cmd_wr_r <= 1'b0;
			cmd_wide_r <= 1'b0;
			cmd_rmw_r <= 1'b0;
		end else if (wr_en && !busy && PADDR == cbi_pkg::OFS_CMD) begin
			cmd_pend_r <= 1'b1;
			cmd_wr_r <= PWDATA[cbi_pkg::CM_WR];
			cmd_rmw_r <= PWDATA[cbi_pkg::CM_RMW];
			cmd_wide_r <= PWDATA[cbi_pkg::CM_RMW] ? ~flags_r.m
				: PWDATA[cbi_pkg::CM_WIDE];
		end else if (fall_tick && state_r == cbi_pkg::ST_IDLE && !int_any)
			cmd_pend_r <= 1'b0;
	end

	// ==========================================================
	// interrupt inputs
	assign nmi_edge = nmi_d_r & ~irqs_s[2];
	assign wake = cancel_pend_r | nmi_pend_r | ~irqs_s[1];

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			armed_r <= 1'b1;
			cancel_pend_r <= 1'b0;
			inhibit_r <= 1'b0;
		end else begin
			if (irqs_s[0])
				armed_r <= 1'b1;
			if (!irqs_s[0] && phi2_w && armed_r) begin
				armed_r <= 1'b0;
				cancel_pend_r <= 1'b1;
				inhibit_r <= 1'b1;
			end else if (fall_tick && state_r == cbi_pkg::ST_IDLE &&
					int_any && kind_sel == cbi_pkg::K_CANCEL) begin
				cancel_pend_r <= 1'b0;
				inhibit_r <= 1'b0;
			end
		end
	end

	// a new edge wins over the clear of the one being taken
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			nmi_d_r <= 1'b1;
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_d_r <= irqs_s[2];
			if (nmi_edge)
				nmi_pend_r <= 1'b1;
			else if (fall_tick && state_r == cbi_pkg::ST_IDLE &&
					int_any && kind_sel == cbi_pkg::K_NMI)
				nmi_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			waiting_r <= 1'b0;
		else if (waiting_r && wake)
			waiting_r <= 1'b0;
		else if (wr_en && PADDR == cbi_pkg::OFS_CTRL &&
				PWDATA[cbi_pkg::CB_WAIT])
			waiting_r <= 1'b1;
	end

	// recognition point: instruction end, or wake from waiting
	always_ff @(posedge CLOCK) begin
		if (RST)
			boundary_r <= 1'b0;
		else if (wr_en && PADDR == cbi_pkg::OFS_INSTR_END)
			boundary_r <= 1'b1;
		else if (waiting_r && wake)
			boundary_r <= 1'b1;
		else if (fall_tick && state_r == cbi_pkg::ST_IDLE)
			boundary_r <= 1'b0;
	end

	// irq is a level: it counts only if still low here
	assign int_any = boundary_r & (cancel_pend_r | nmi_pend_r |
		(~irqs_s[1] & ~flags_r.i));

	always_comb begin
		if (cancel_pend_r)
			kind_sel = cbi_pkg::K_CANCEL;
		else if (nmi_pend_r)
			kind_sel = cbi_pkg::K_NMI;
		else
			kind_sel = cbi_pkg::K_IRQ;
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			kind_r <= cbi_pkg::K_IRQ;
			ret_r <= 16'h0;
		end else if (fall_tick && state_r == cbi_pkg::ST_IDLE && int_any) begin
			kind_r <= kind_sel;
			ret_r <= (kind_sel == cbi_pkg::K_CANCEL) ? opaddr_r : pc_r;
		end
	end

	always_comb begin
		case (kind_r)
		cbi_pkg::K_CANCEL: vec_w = flags_r.e ? cbi_pkg::VEC_CANCEL_EMU
			: cbi_pkg::VEC_CANCEL_NAT;
		cbi_pkg::K_NMI: vec_w = flags_r.e ? cbi_pkg::VEC_NMI_EMU
			: cbi_pkg::VEC_NMI_NAT;
		default: vec_w = flags_r.e ? cbi_pkg::VEC_IRQ_EMU
			: cbi_pkg::VEC_IRQ_NAT;
		endcase
	end

	// ==========================================================
	// bus cycle sequencer, one state per phase-2 period
	always_comb begin
		state_nxt = state_r;
		case (state_r)
		cbi_pkg::ST_IDLE:
			if (int_any)
				state_nxt = cbi_pkg::ST_PUSH_HI;
			else if (cmd_pend_r)
				state_nxt = (cmd_wr_r && !cmd_rmw_r) ? cbi_pkg::ST_WR_LO
					: cbi_pkg::ST_RD_LO;
		cbi_pkg::ST_RD_LO:
			if (cmd_wide_r)
				state_nxt = cbi_pkg::ST_RD_HI;
			else
				state_nxt = cmd_rmw_r ? cbi_pkg::ST_MODIFY
					: cbi_pkg::ST_IDLE;
		cbi_pkg::ST_RD_HI:
			state_nxt = cmd_rmw_r ? cbi_pkg::ST_MODIFY : cbi_pkg::ST_IDLE;
		cbi_pkg::ST_MODIFY:
			state_nxt = cmd_wide_r ? cbi_pkg::ST_WR_HI : cbi_pkg::ST_WR_LO;
		cbi_pkg::ST_WR_LO:
			state_nxt = (cmd_wide_r && !cmd_rmw_r) ? cbi_pkg::ST_WR_HI
				: cbi_pkg::ST_IDLE;
		cbi_pkg::ST_WR_HI:
			state_nxt = cmd_rmw_r ? cbi_pkg::ST_WR_LO : cbi_pkg::ST_IDLE;
		cbi_pkg::ST_PUSH_HI: state_nxt = cbi_pkg::ST_PUSH_LO;
		cbi_pkg::ST_PUSH_LO: state_nxt = cbi_pkg::ST_VEC_LO;
		cbi_pkg::ST_VEC_LO: state_nxt = cbi_pkg::ST_VEC_HI;
		default: state_nxt = cbi_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			state_r <= cbi_pkg::ST_IDLE;
		else if (fall_tick)
			state_r <= state_nxt;
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			vec_lo_r <= 8'h0;
		else if (fall_tick && state_r == cbi_pkg::ST_VEC_LO)
			vec_lo_r <= mux_s;
	end

	assign addr_p1 = addr_r + 24'h1;
	assign addr_hi_unused = 8'h00;

	function automatic cbi_pkg::cbi_cyc_t cyc_of(
			input cbi_pkg::cbi_state_t s);
		cbi_pkg::cbi_cyc_t c;
		c = '0;
		c.addr = addr_r;
		c.lock = cmd_rmw_r && s != cbi_pkg::ST_IDLE &&
			s < cbi_pkg::ST_PUSH_HI;
		case (s)
		cbi_pkg::ST_RD_HI: c.addr = addr_p1;
		cbi_pkg::ST_MODIFY: c.addr = cmd_wide_r ? addr_p1 : addr_r;
		cbi_pkg::ST_WR_LO: begin
			c.wr = 1'b1;
			c.wdata = data_r[7:0];
		end
		cbi_pkg::ST_WR_HI: begin
			c.wr = 1'b1;
			c.addr = addr_p1;
			c.wdata = data_r[15:8];
		end
		cbi_pkg::ST_PUSH_HI: begin
			c.wr = 1'b1;
			c.addr = {addr_hi_unused, sp_r};
			c.wdata = ret_r[15:8];
		end
		cbi_pkg::ST_PUSH_LO: begin
			c.wr = 1'b1;
			c.addr = {addr_hi_unused, sp_r - 16'h1};
			c.wdata = ret_r[7:0];
		end
		cbi_pkg::ST_VEC_LO: c.addr = {addr_hi_unused, vec_w};
		cbi_pkg::ST_VEC_HI: c.addr = {addr_hi_unused, vec_w + 16'h1};
		default: c.addr = addr_r;
		endcase
		return c;
	endfunction

	// processes, not assigns, so the function's register reads wake them
	always_comb cyc_next = cyc_of(state_nxt);
	always_comb cyc_now = cyc_of(state_r);

	// ==========================================================
	// pin drivers; write data taken late so modify results land
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			cur_r <= '0;
			ADDR_LINES <= 16'h0;
			mux_r <= 8'h0;
			mux_oe_n_r <= 1'b1;
			rw_r <= 1'b1;
			lock_n_r <= 1'b1;
		end else if (fall_tick) begin
			cur_r <= cyc_next;
			ADDR_LINES <= cyc_next.addr[15:0];
			mux_r <= cyc_next.addr[23:16];
			mux_oe_n_r <= 1'b0;
			rw_r <= ~cyc_next.wr;
			lock_n_r <= ~cyc_next.lock;
		end else if (rise_tick) begin
			mux_r <= cyc_now.wdata;
			mux_oe_n_r <= ~cur_r.wr;
		end
	end

	assign MUXED_BANK_DATA_BUS = mux_r;
	assign RW = rw_r;
	assign BUS_LOCK_N = lock_n_r;
	// enables must float with no clock, so they bypass the flops
	assign ADDR_LINES_OE_N = ~BUS_DRIVE_EN;
	assign RW_OE_N = ~BUS_DRIVE_EN;
	assign MUXED_BANK_DATA_BUS_OE_N = mux_oe_n_r | ~BUS_DRIVE_EN;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			width_r <= 1'b1;
			emu_r <= 1'b1;
		end else begin
			emu_r <= flags_r.e;
			if (mid_tick)
				width_r <= phi2_w ? flags_r.m : flags_r.x;
		end
	end
	assign WIDTH_FLAGS = width_r;
	assign EMU_STATUS = emu_r;

	// lock length helper
	always_ff @(posedge CLOCK) begin
		if (RST)
			lk_cnt_r <= 3'h0;
		else if (fall_tick && cyc_next.lock)
			lk_cnt_r <= lock_n_r ? 3'h1 : lk_cnt_r + 3'h1;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	property p_inhibit;
		(inhibit_r && wr_en && PADDR == cbi_pkg::OFS_PC) |=> $stable(pc_r);
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("pc changed during cancelled instruction");

	property p_ret;
		(fall_tick && state_r == cbi_pkg::ST_IDLE && int_any &&
			cancel_pend_r) |=> ret_r == $past(opaddr_r);
	endproperty
	a_ret: assert property (p_ret)
		else $error("cancel return address wrong");

	property p_vec_cancel;
		(state_r == cbi_pkg::ST_VEC_LO && kind_r == cbi_pkg::K_CANCEL)
			|-> cur_r.addr == (flags_r.e ? 24'h00fff8 : 24'h00ffe8);
	endproperty
	a_vec_cancel: assert property (p_vec_cancel)
		else $error("cancel vector address wrong");

	property p_vec_nmi;
		(state_r == cbi_pkg::ST_VEC_HI && kind_r == cbi_pkg::K_NMI)
			|-> cur_r.addr == (flags_r.e ? 24'h00fffb : 24'h00ffeb);
	endproperty
	a_vec_nmi: assert property (p_vec_nmi)
		else $error("nmi vector address wrong");

	property p_cancel_take;
		(!irqs_s[0] && phi2_w && armed_r) |=> cancel_pend_r && inhibit_r;
	endproperty
	a_cancel_take: assert property (p_cancel_take)
		else $error("cancel not latched");

	property p_float;
		!BUS_DRIVE_EN |-> ADDR_LINES_OE_N && RW_OE_N &&
			MUXED_BANK_DATA_BUS_OE_N;
	endproperty
	a_float: assert property (p_float)
		else $error("buffers active with drive disabled");

	property p_read_float;
		(phi2_w && $past(phi2_w) && !cur_r.wr) |-> mux_oe_n_r && RW;
	endproperty
	a_read_float: assert property (p_read_float)
		else $error("bus driven in read data half");

	property p_bank;
		$fell(phi2_w) |-> MUXED_BANK_DATA_BUS == cur_r.addr[23:16];
	endproperty
	a_bank: assert property (p_bank)
		else $error("bank bits missing in first half");

	property p_emu;
		##1 EMU_STATUS == $past(flags_r.e);
	endproperty
	a_emu: assert property (p_emu)
		else $error("emulation status lags");

	property p_irq_mask;
		(fall_tick && state_r == cbi_pkg::ST_IDLE && int_any &&
			kind_sel == cbi_pkg::K_IRQ) |-> !flags_r.i && !irqs_s[1];
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("masked irq taken");

	property p_wake;
		(waiting_r && wake) |=> boundary_r && !waiting_r;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wait did not wake");

	property p_lock_len;
		(fall_tick && !lock_n_r && !cyc_next.lock) |-> lk_cnt_r ==
			(cmd_wide_r ? cbi_pkg::LOCK_LONG : cbi_pkg::LOCK_SHORT);
	endproperty
	a_lock_len: assert property (p_lock_len)
		else $error("lock length wrong");

	property p_nmi_latch;
		nmi_edge |=> nmi_pend_r;
	endproperty
	a_nmi_latch: assert property (p_nmi_latch)
		else $error("nmi edge lost");
endmodule // cbi_top

/* File: verification/cbi_mem_model.sv */
// cbi_mem_model: external memory on the multiplexed bus.
// assumes the block's clock; index is address bit 15 plus low byte.
module cbi_mem_model (
	// clock and bus pins
	input wire logic clk,
	input wire logic [15:0] addr,
	input wire logic [7:0] bus,
	input wire logic bus_oe_n,
	input wire logic rw,
	input wire logic phi2,
	// read data to the pins
	output logic [7:0] sense
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:511];
	logic [7:0] last_r;
	logic [8:0] idx;
	assign idx = {addr[15], addr[7:0]};
	initial begin
		for (int i = 0; i < 512; i++) begin
			mem[i] = i[7:0] ^ 8'h3c;
		end
		last_r = 8'h00;
	end
	// released bus shows the inverse so stale data never matches
	assign sense = (phi2 && rw) ? mem[idx] : ~last_r;
	always @(posedge clk) begin
		if (phi2 && rw) begin
			last_r <= mem[idx];
		end
		if (phi2 && !rw && !bus_oe_n) begin
			mem[idx] <= bus;
		end
	end
endmodule // cbi_mem_model

/* File: verification/cbi_top_tb_top.sv */
// cbi_top_tb_top: register-driven bus, lock and interrupt scenarios.
// assumes cbi_top with HALF=4 and the memory model on its pins.
module cbi_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, psel, penable, pwrite, be, cancel_n, irq_n, nmi_n;
	logic [7:0] paddr, sense, bus;
	logic [31:0] pwdata, prdata, r;
	logic pready, pslverr, rw, rw_oe_n, a_oe_n, b_oe_n, phi2;
	logic emu, wflags, lock_n, phi1;
	logic [15:0] addr;
	int fails = 0, comparisons = 0, cyc = 0, lockc = 0;
	cbi_top #(.HALF(4)) dut (.CLOCK(clk), .RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .ADDR_LINES(addr), .ADDR_LINES_OE_N(a_oe_n),
		.MUXED_BANK_DATA_BUS(bus), .MUXED_BANK_DATA_BUS_SENSE(sense),
		.MUXED_BANK_DATA_BUS_OE_N(b_oe_n), .RW(rw), .RW_OE_N(rw_oe_n),
		.BUS_DRIVE_EN(be), .CANCEL_N(cancel_n), .IRQ_N(irq_n),
		.NMI_N(nmi_n), .EMU_STATUS(emu), .WIDTH_FLAGS(wflags),
		.BUS_LOCK_N(lock_n), .PHI1_OUT(phi1), .PHI2_OUT(phi2));
	cbi_mem_model mem (.clk(clk), .addr(addr), .bus(bus),
		.bus_oe_n(b_oe_n), .rw(rw), .phi2(phi2), .sense(sense));
	// ==========================================================
	// clock, timeout, lock counter
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (lock_n === 1'b0) lockc++;
		if (cyc == 20000) begin
			fails++;
			finish_test();
		end
	end
	// ==========================================================
	// shared tasks
	task automatic finish_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_idle();
		repeat (16) @(posedge clk);
		for (int i = 0; i < 200; i++) begin
			apb(0, cbi_pkg::OFS_STATUS, 0);
			if (r[0] === 1'b0) break;
		end
		chk("idle", 32'h0, {31'h0, r[0]});
	endtask
	function automatic logic [7:0] vb(logic [15:0] a);
		return a[7:0] ^ 8'h3c;
	endfunction
	// wide read through the block; result left in r
	task automatic rd16(logic [23:0] a);
		apb(1, cbi_pkg::OFS_ADDR, {8'h0, a});
		apb(1, cbi_pkg::OFS_CMD, 32'h2);
		wait_idle();
		apb(0, cbi_pkg::OFS_DATA, 0);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset_unmapped();
		apb(0, cbi_pkg::OFS_CTRL, 0);
		chk("ctrl", 32'h0000000f, r);
		chk("emu_rst", 32'h1, {31'h0, emu});
		apb(0, 8'h40, 0);
		chk("slverr", 32'h1, {31'h0, pslverr});
	endtask
	task automatic t_bus_enable();
		be <= 0;
		@(posedge clk);
		chk("oe_off", 32'h7, {29'h0, a_oe_n, rw_oe_n, b_oe_n});
		be <= 1;
		@(posedge clk);
		chk("oe_on", 32'h0, {30'h0, a_oe_n, rw_oe_n});
		@(posedge clk iff phi2 === 1'b0);
		chk("bank_drv", 32'h0, {31'h0, b_oe_n});
		@(posedge clk iff phi2 === 1'b1);
		chk("data_float", 32'h1, {31'h0, b_oe_n});
	endtask
	task automatic t_rmw_then_wide();
		apb(1, cbi_pkg::OFS_ADDR, 32'h20);
		lockc = 0;
		apb(1, cbi_pkg::OFS_CMD, 32'h4);
		wait_idle();
		chk("lock", 32'd24, lockc);
		apb(1, cbi_pkg::OFS_CMD, 32'h2);
		wait_idle();
		apb(0, cbi_pkg::OFS_DATA, 0);
		chk("data", {16'h0, vb(16'h21), vb(16'h20) + 8'h1}, r);
	endtask
	task automatic t_nmi();
		nmi_n <= 0;
		repeat (4) @(posedge clk);
		apb(1, cbi_pkg::OFS_INSTR_END, 32'h1234);
		wait_idle();
		apb(0, cbi_pkg::OFS_PC, 0);
		chk("pc", {16'h0, vb(16'hfffb), vb(16'hfffa)}, r);
		apb(0, cbi_pkg::OFS_SP, 0);
		chk("sp", 32'h01fd, r);
		rd16(24'h0001fe);
		chk("ret_nmi", 32'h1234, r);
		apb(1, cbi_pkg::OFS_INSTR_END, 32'h0456);
		wait_idle();
		apb(0, cbi_pkg::OFS_PC, 0);
		chk("held", 32'h0456, r);
		nmi_n <= 1;
	endtask
	task automatic t_cancel();
		apb(1, cbi_pkg::OFS_OPADDR, 32'h0200);
		cancel_n <= 0;
		repeat (12) @(posedge clk);
		cancel_n <= 1;
		apb(1, cbi_pkg::OFS_PC, 32'h5555);
		apb(0, cbi_pkg::OFS_PC, 0);
		chk("pc_kept", 32'h0456, r);
		apb(0, cbi_pkg::OFS_STATUS, 0);
		chk("cancel_st", 32'h18, r);
		apb(1, cbi_pkg::OFS_INSTR_END, 32'h3333);
		wait_idle();
		apb(0, cbi_pkg::OFS_PC, 0);
		chk("pc_cancel", {16'h0, vb(16'hfff9), vb(16'hfff8)}, r);
		rd16(24'h0001fc);
		chk("ret_cancel", 32'h0200, r);
	endtask
	// native mode, M set, X clear, I clear, then wait for a request
	task automatic t_irq_wait();
		apb(1, cbi_pkg::OFS_CTRL, 32'h12);
		repeat (2) @(posedge clk);
		chk("emu", 32'h0, {31'h0, emu});
		@(posedge clk iff phi2 === 1'b1);
		repeat (2) @(posedge clk);
		chk("width_m", 32'h1, {31'h0, wflags});
		repeat (4) @(posedge clk);
		chk("width_x", 32'h0, {31'h0, wflags});
		apb(0, cbi_pkg::OFS_STATUS, 0);
		chk("waiting", 32'h2, r);
		irq_n <= 0;
		wait_idle();
		apb(0, cbi_pkg::OFS_PC, 0);
		chk("pc_irq", {16'h0, vb(16'hffef), vb(16'hffee)}, r);
		irq_n <= 1;
	endtask
	task automatic t_stop();
		apb(1, cbi_pkg::OFS_CTRL, 32'h2a);
		repeat (16) @(posedge clk);
		chk("parked", 32'h2, {30'h0, phi2, phi1});
		apb(0, cbi_pkg::OFS_PC, 0);
		chk("retained", {16'h0, vb(16'hffef), vb(16'hffee)}, r);
		apb(1, cbi_pkg::OFS_CTRL, 32'ha);
		repeat (4) @(posedge clk);
		apb(0, cbi_pkg::OFS_STATUS, 0);
		chk("resumed", 32'h0, r);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst = 1;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 8'h00;
		pwdata = 32'h0;
		be = 1;
		cancel_n = 1;
		irq_n = 1;
		nmi_n = 1;
		repeat (10) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		t_reset_unmapped();
		t_bus_enable();
		t_rmw_then_wide();
		t_nmi();
		t_cancel();
		t_irq_wait();
		t_stop();
		finish_test();
	end
endmodule // cbi_top_tb_top
